// file: rtl/oag_ea_calc.v
`timescale 1ns/1ns
`default_nettype none
`include "oag_defines.vh"

module oag_ea_calc (
	input  wire [2:0]  i_mode,
	input  wire [15:0] i_sel_ptr,
	input  wire [15:0] i_ptr1,
	input  wire [15:0] i_ptr2,
	input  wire [15:0] i_addr,
	input  wire [15:0] i_ind,
	input  wire [15:0] i_off,
	input  wire [2:0]  i_bit_num,
	output reg  [15:0] o_ea,
	output reg  [2:0]  o_bit
);

	// Carries are dropped on purpose: addresses wrap in 64K
	wire [16:0] idx_sum = {1'b0, i_ind} + {1'b0, i_off};
	wire [16:0] str_sum = {1'b0, i_ptr1} + {4'h0, i_ptr2[15:3]};

	// ----------------------------------------
	// Effective address and bit select
	// ----------------------------------------
	always @* begin
		o_bit = i_bit_num;
		case (i_mode)
			`OAG_M_DIRECT:   o_ea = i_addr;
			`OAG_M_REGIND:   o_ea = i_sel_ptr;
			`OAG_M_INDIRECT: o_ea = i_ind;
			`OAG_M_INDEXED:  o_ea = idx_sum[15:0];
			`OAG_M_DBLREG: begin
				// Sum wraps in 64K; strings may straddle the top of memory
				o_ea  = str_sum[15:0];
				o_bit = i_ptr2[2:0];
			end
			default:         o_ea = 16'h0000;
		endcase
	end

endmodule

`default_nettype wire

// file: rtl/oag_top.v
`timescale 1ns/1ns
`default_nettype none
`include "oag_defines.vh"

module oag_top (
	input  wire        i_ref_clk,
	input  wire        i_rst_n,
	input  wire        i_start,
	input  wire [1:0]  i_op_class,
	input  wire [2:0]  i_mode,
	input  wire        i_ptr_sel,
	input  wire        i_word,
	input  wire        i_addr_long,
	input  wire        i_off_long,
	input  wire        i_dst_acc,
	input  wire        i_dst_long,
	input  wire [1:0]  i_bit_op,
	input  wire [2:0]  i_bit_num,
	input  wire [15:0] i_ptr1,
	input  wire [15:0] i_ptr2,
	input  wire        i_ib_valid,
	input  wire [7:0]  i_ib_data,
	input  wire        i_mem_rvalid,
	input  wire [7:0]  i_mem_rdata,
	output wire        o_ib_take,
	output wire        o_mem_rd,
	output wire [15:0] o_mem_addr,
	output wire        o_busy,
	output wire        o_done,
	output wire        o_illegal,
	output wire [15:0] o_src_ea,
	output wire        o_src_is_imm,
	output wire [15:0] o_imm,
	output wire        o_src_word,
	output wire [2:0]  o_src_reg,
	output wire        o_src_ram,
	output wire        o_bit_valid,
	output wire [2:0]  o_bit_idx,
	output wire        o_dst_valid,
	output wire [15:0] o_dst_ea,
	output wire [2:0]  o_dst_reg,
	output wire        o_write_back
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [9:0] S_IDLE = 10'h001;
	localparam [9:0] S_DLO  = 10'h002;
	localparam [9:0] S_DHI  = 10'h004;
	localparam [9:0] S_ALO  = 10'h008;
	localparam [9:0] S_AHI  = 10'h010;
	localparam [9:0] S_OLO  = 10'h020;
	localparam [9:0] S_OHI  = 10'h040;
	localparam [9:0] S_RLO  = 10'h080;
	localparam [9:0] S_RHI  = 10'h100;
	localparam [9:0] S_DONE = 10'h200;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function [2:0] reg_code;
		input [15:0] a;
		begin
			case (a)
				`OAG_A_SP:   reg_code = `OAG_R_SP;
				`OAG_A_PC:   reg_code = `OAG_R_PC;
				`OAG_A_ACC:  reg_code = `OAG_R_ACC;
				`OAG_A_K:    reg_code = `OAG_R_K;
				`OAG_A_PTR1: reg_code = `OAG_R_PTR1;
				`OAG_A_PTR2: reg_code = `OAG_R_PTR2;
				default:     reg_code = `OAG_R_NONE;
			endcase
		end
	endfunction

	function [9:0] after_a;
		input [2:0] m;
		after_a = (m == `OAG_M_INDEXED) ? S_OLO : (m == `OAG_M_INDIRECT) ? S_RLO : S_DONE;
	endfunction

	// Register pointer modes (REGIND, DBLREG) need no stream byte
	function [9:0] src_entry;
		input [2:0] m;
		src_entry = (m == `OAG_M_REGIND || m == `OAG_M_DBLREG) ? S_DONE : S_ALO;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [9:0]  state_ff,   nxt_state;
	reg [15:0] dadr_ff,    nxt_dadr;
	reg [15:0] a_ff,       nxt_a;
	reg [15:0] off_ff,     nxt_off;
	reg [15:0] ind_ff,     nxt_ind;
	reg [15:0] maddr_ff,   nxt_maddr;
	reg        pend_ff,    nxt_pend;
	reg        take_ff,    nxt_take;
	reg        rd_ff,      nxt_rd;
	reg [1:0]  class_ff,   bop_ff;
	reg [2:0]  mode_ff,    bnum_ff;
	reg        psel_ff,    word_ff,  along_ff, olong_ff, dacc_ff,  dlong_ff, ill_ff;
	reg        busy_ff,    done_ff,  illo_ff,  simm_ff,  sword_ff, sram_ff,  bval_ff, dval_ff, wb_ff;
	reg [15:0] sea_ff,     imm_ff,   dea_ff;
	reg [2:0]  sreg_ff,    bidx_ff,  dreg_ff;

	wire        fetch_st,  take,     is_bit,   legal;
	wire [15:0] calc_ea,   sel_ptr,  dst_ea;
	wire [2:0]  calc_bit;

	assign fetch_st = |(state_ff & (S_DLO | S_DHI | S_ALO | S_AHI | S_OLO | S_OHI));
	// One byte per two cycles: the source sees the take pulse before offering the next byte
	assign take     = fetch_st & i_ib_valid & ~take_ff;
	assign is_bit   = (bop_ff != `OAG_B_NONE);
	assign sel_ptr  = psel_ff ? i_ptr2 : i_ptr1;
	assign dst_ea   = dacc_ff ? `OAG_A_ACC : dadr_ff;

	// ----------------------------------------
	// Mode legality
	// ----------------------------------------
	assign legal =
		(i_op_class == `OAG_C_SINGLE) ?
			((i_mode <= `OAG_M_INDEXED) ||
			 (i_mode == `OAG_M_DBLREG && i_bit_op != `OAG_B_NONE)) :
		(i_op_class == `OAG_C_TWO || i_op_class == `OAG_C_CMP) ?
			(i_bit_op == `OAG_B_NONE &&
			 (i_dst_acc ? (i_mode <= `OAG_M_IMMED) :
			  (i_mode == `OAG_M_DIRECT || i_mode == `OAG_M_IMMED))) :
		1'b0;

	oag_ea_calc u_calc (
		.i_mode    (mode_ff),
		.i_sel_ptr (sel_ptr),
		.i_ptr1    (i_ptr1),
		.i_ptr2    (i_ptr2),
		.i_addr    (a_ff),
		.i_ind     (ind_ff),
		.i_off     (off_ff),
		.i_bit_num (bnum_ff),
		.o_ea      (calc_ea),
		.o_bit     (calc_bit)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always @* begin
		nxt_state = state_ff;
		nxt_dadr  = dadr_ff;
		nxt_a     = a_ff;
		nxt_off   = off_ff;
		nxt_ind   = ind_ff;
		nxt_pend  = pend_ff;
		nxt_take  = take;
		nxt_rd    = 1'b0;
		nxt_maddr = maddr_ff;
		case (state_ff)
			S_IDLE: begin
				if (i_start) begin
					nxt_dadr  = 16'h0000;
					nxt_a     = 16'h0000;
					nxt_off   = 16'h0000;
					nxt_ind   = 16'h0000;
					if (!legal)
						nxt_state = S_DONE;
					else if (i_op_class != `OAG_C_SINGLE && !i_dst_acc)
						nxt_state = S_DLO;
					else
						nxt_state = src_entry(i_mode);
				end
			end
			S_DLO: begin
				if (take) begin
					nxt_dadr = {8'h00, i_ib_data};
					nxt_state = dlong_ff ? S_DHI : src_entry(mode_ff);
				end
			end
			S_DHI: begin
				if (take) begin
					nxt_dadr[15:8] = i_ib_data;
					nxt_state = src_entry(mode_ff);
				end
			end
			S_ALO: begin
				if (take) begin
					nxt_a = {8'h00, i_ib_data};
					if ((mode_ff == `OAG_M_DIRECT && along_ff) || (mode_ff == `OAG_M_IMMED && word_ff))
						nxt_state = S_AHI;
					else
						nxt_state = after_a(mode_ff);
				end
			end
			S_AHI: begin
				if (take) begin
					nxt_a[15:8] = i_ib_data;
					nxt_state = S_DONE;
				end
			end
			S_OLO: begin
				if (take) begin
					nxt_off = {8'h00, i_ib_data};
					nxt_state = olong_ff ? S_OHI : S_RLO;
				end
			end
			S_OHI: begin
				if (take) begin
					nxt_off[15:8] = i_ib_data;
					nxt_state = S_RLO;
				end
			end
			S_RLO: begin
				if (!pend_ff) begin
					nxt_rd    = 1'b1;
					nxt_maddr = {`OAG_BP_HI, a_ff[7:0]};
					nxt_pend  = 1'b1;
				end else if (i_mem_rvalid) begin
					nxt_ind[7:0] = i_mem_rdata;
					nxt_pend  = 1'b0;
					nxt_state = S_RHI;
				end
			end
			S_RHI: begin
				if (!pend_ff) begin
					nxt_rd    = 1'b1;
					// Wraps inside the base page so a pointer never leaves it
					nxt_maddr = {`OAG_BP_HI, a_ff[7:0] + 8'h01};
					nxt_pend  = 1'b1;
				end else if (i_mem_rvalid) begin
					nxt_ind[15:8] = i_mem_rdata;
					nxt_pend  = 1'b0;
					nxt_state = S_DONE;
				end
			end
			S_DONE:  nxt_state = S_IDLE;
			default: nxt_state = S_IDLE;
		endcase
	end

	// ----------------------------------------
	// Clocked state and results
	// ----------------------------------------
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= S_IDLE;
			{class_ff, mode_ff, bop_ff, bnum_ff} <= 10'h000;
			{psel_ff, word_ff, along_ff, olong_ff, dacc_ff, dlong_ff, ill_ff} <= 7'h00;
			dadr_ff  <= 16'h0000;
			a_ff     <= 16'h0000;
			off_ff   <= 16'h0000;
			ind_ff   <= 16'h0000;
			pend_ff  <= 1'b0;
			take_ff  <= 1'b0;
			rd_ff    <= 1'b0;
			maddr_ff <= 16'h0000;
			{busy_ff, done_ff, illo_ff, simm_ff, sword_ff, sram_ff, bval_ff, dval_ff, wb_ff} <= 9'h000;
			{sea_ff, imm_ff, dea_ff} <= 48'h000000000000;
			{sreg_ff, bidx_ff, dreg_ff} <= 9'h000;
		end else begin
			state_ff <= nxt_state;
			dadr_ff  <= nxt_dadr;
			a_ff     <= nxt_a;
			off_ff   <= nxt_off;
			ind_ff   <= nxt_ind;
			pend_ff  <= nxt_pend;
			take_ff  <= nxt_take;
			rd_ff    <= nxt_rd;
			maddr_ff <= nxt_maddr;
			// Busy follows the next state so the port needs no gate after the flop
			busy_ff  <= (nxt_state != S_IDLE);
			done_ff  <= (state_ff == S_DONE);
			if (state_ff == S_IDLE && i_start) begin
				class_ff <= i_op_class;
				mode_ff  <= i_mode;
				psel_ff  <= i_ptr_sel;
				word_ff  <= i_word;
				along_ff <= i_addr_long;
				olong_ff <= i_off_long;
				dacc_ff  <= i_dst_acc;
				dlong_ff <= i_dst_long;
				bop_ff   <= i_bit_op;
				bnum_ff  <= i_bit_num;
				ill_ff   <= ~legal;
			end
			if (state_ff == S_DONE) begin
				illo_ff  <= ill_ff;
				simm_ff  <= ~ill_ff & (mode_ff == `OAG_M_IMMED);
				imm_ff   <= (mode_ff == `OAG_M_IMMED) ? a_ff : 16'h0000;
				sea_ff   <= calc_ea;
				sword_ff <= word_ff & ~is_bit;
				// Mapped registers answer like memory, so the core just reroutes the access
				sreg_ff  <= (mode_ff == `OAG_M_IMMED) ? `OAG_R_NONE : reg_code(calc_ea);
				sram_ff  <= (mode_ff != `OAG_M_IMMED) && (calc_ea <= `OAG_RAM_TOP);
				bval_ff  <= ~ill_ff & is_bit;
				bidx_ff  <= calc_bit;
				dval_ff  <= ~ill_ff & (class_ff != `OAG_C_SINGLE);
				dea_ff   <= (class_ff == `OAG_C_SINGLE) ? calc_ea : dst_ea;
				dreg_ff  <= (class_ff == `OAG_C_SINGLE) ? reg_code(calc_ea) : reg_code(dst_ea);
				wb_ff    <= ~ill_ff & ((class_ff == `OAG_C_TWO) ||
					(class_ff == `OAG_C_SINGLE && bop_ff != `OAG_B_TEST));
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_ib_take    = take_ff;
	assign o_mem_rd     = rd_ff;
	assign o_mem_addr   = maddr_ff;
	assign o_busy       = busy_ff;
	assign o_done       = done_ff;
	assign o_illegal    = illo_ff;
	assign o_src_ea     = sea_ff;
	assign o_src_is_imm = simm_ff;
	assign o_imm        = imm_ff;
	assign o_src_word   = sword_ff;
	assign o_src_reg    = sreg_ff;
	assign o_src_ram    = sram_ff;
	assign o_bit_valid  = bval_ff;
	assign o_bit_idx    = bidx_ff;
	assign o_dst_valid  = dval_ff;
	assign o_dst_ea     = dea_ff;
	assign o_dst_reg    = dreg_ff;
	assign o_write_back = wb_ff;

endmodule

`default_nettype wire

// file: shared/oag_defines.vh
`ifndef OAG_DEFINES_VH
`define OAG_DEFINES_VH

// ----------------------------------------
// Address space
// ----------------------------------------
`define OAG_AW          16
`define OAG_RAM_TOP     16'h00BF
`define OAG_BP_HI       8'h00

// ----------------------------------------
// Operand addressing modes
// ----------------------------------------
`define OAG_M_DIRECT    3'h0
`define OAG_M_REGIND    3'h1
`define OAG_M_INDIRECT  3'h2
`define OAG_M_INDEXED   3'h3
`define OAG_M_IMMED     3'h4
`define OAG_M_DBLREG    3'h5

// ----------------------------------------
// Instruction classes and bit operations
// ----------------------------------------
`define OAG_C_SINGLE    2'h0
`define OAG_C_TWO       2'h1
`define OAG_C_CMP       2'h2
`define OAG_B_NONE      2'h0
`define OAG_B_SET       2'h1
`define OAG_B_CLEAR     2'h2
`define OAG_B_TEST      2'h3

// ----------------------------------------
// Memory-mapped core registers
// ----------------------------------------
`define OAG_A_SP        16'h00C4
`define OAG_A_PC        16'h00C6
`define OAG_A_ACC       16'h00C8
`define OAG_A_K         16'h00CA
`define OAG_A_PTR1      16'h00CC
`define OAG_A_PTR2      16'h00CE
`define OAG_R_NONE      3'h0
`define OAG_R_SP        3'h1
`define OAG_R_PC        3'h2
`define OAG_R_ACC       3'h3
`define OAG_R_K         3'h4
`define OAG_R_PTR1      3'h5
`define OAG_R_PTR2      3'h6

`endif

// file: testbench/oag_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "oag_defines.vh"

// ----------------------------------------
// Operand addressing checker
// ----------------------------------------
module oag_chk (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic        i_start,
	input wire logic [1:0]  i_op_class,
	input wire logic [2:0]  i_mode,
	input wire logic [1:0]  i_bit_op,
	input wire logic [2:0]  i_bit_num,
	input wire logic        i_dst_acc,
	input wire logic [15:0] i_ptr1,
	input wire logic [15:0] i_ptr2,
	input wire logic        o_busy,
	input wire logic        o_done,
	input wire logic        o_illegal,
	input wire logic        o_ib_take,
	input wire logic        o_mem_rd,
	input wire logic [15:0] o_mem_addr,
	input wire logic [15:0] o_src_ea,
	input wire logic        o_src_is_imm,
	input wire logic        o_src_word,
	input wire logic [2:0]  o_src_reg,
	input wire logic        o_src_ram,
	input wire logic        o_bit_valid,
	input wire logic [2:0]  o_bit_idx,
	input wire logic [15:0] o_dst_ea,
	input wire logic [2:0]  o_dst_reg,
	input wire logic        o_write_back
);
	logic [1:0] cls_ff;
	logic [2:0] mode_ff;
	logic       dacc_ff;
	logic [2:0] bnum_ff;
	wire        fin = o_done && !o_illegal;
	wire        go  = i_start && !o_busy;

	// Decode fields only count on the start edge, so keep them for the result check
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cls_ff  <= 2'h0;
			mode_ff <= 3'h0;
			dacc_ff <= 1'b0;
			bnum_ff <= 3'h0;
		end else if (go) begin
			cls_ff  <= i_op_class;
			mode_ff <= i_mode;
			dacc_ff <= i_dst_acc;
			bnum_ff <= i_bit_num;
		end
	end

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	chk_ptr_base_page: assert property (o_mem_rd |-> o_mem_addr[15:8] == 8'h00)
		else $error("pointer fetch outside base page");
	chk_regind_short: assert property (go && i_mode == `OAG_M_REGIND && i_op_class == `OAG_C_SINGLE
		|=> !o_ib_take ##1 (o_done && !o_ib_take)) else $error("pointer operand took stream bytes");
	chk_dbl_needs_bit: assert property (go && i_mode == `OAG_M_DBLREG && i_bit_op == `OAG_B_NONE
		|-> ##2 (o_done && o_illegal)) else $error("bit string mode accepted without bit op");
	chk_single_no_imm: assert property (go && i_mode == `OAG_M_IMMED && i_op_class == `OAG_C_SINGLE
		|-> ##2 (o_done && o_illegal)) else $error("single operand accepted immediate");
	chk_bit_is_byte: assert property (o_done && o_bit_valid |-> !o_src_word)
		else $error("bit op with word access");
	chk_bit_number: assert property (fin && o_bit_valid && mode_ff != `OAG_M_DBLREG |-> o_bit_idx == bnum_ff)
		else $error("bit index differs from opcode");
	chk_dbl_address: assert property (fin && mode_ff == `OAG_M_DBLREG
		|-> o_src_ea == $past(i_ptr1) + ($past(i_ptr2) >> 3) && o_bit_idx == ($past(i_ptr2) & 16'h0007))
		else $error("bit string address wrong");
	chk_cmp_no_write: assert property (fin && cls_ff == `OAG_C_CMP |-> !o_write_back)
		else $error("comparison writes back");
	chk_two_op_write: assert property (fin && cls_ff == `OAG_C_TWO |-> o_write_back)
		else $error("two operand result dropped");
	chk_acc_dest: assert property (fin && cls_ff != `OAG_C_SINGLE && dacc_ff
		|-> o_dst_ea == `OAG_A_ACC && o_dst_reg == `OAG_R_ACC) else $error("accumulator destination wrong");
	chk_ram_flag: assert property (fin && !o_src_is_imm |-> o_src_ram == (o_src_ea <= `OAG_RAM_TOP))
		else $error("on-chip ram flag wrong");
	chk_acc_mapped: assert property (fin && !o_src_is_imm && o_src_ea == `OAG_A_ACC |-> o_src_reg == `OAG_R_ACC)
		else $error("accumulator address not flagged");

	cover property (fin && mode_ff == `OAG_M_DBLREG);
	cover property (o_mem_rd);
	cover property (fin && cls_ff == `OAG_C_CMP);
endmodule

bind oag_top oag_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_op_class(i_op_class),
	.i_mode(i_mode), .i_bit_op(i_bit_op), .i_bit_num(i_bit_num), .i_dst_acc(i_dst_acc), .i_ptr1(i_ptr1),
	.i_ptr2(i_ptr2), .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_ib_take(o_ib_take),
	.o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .o_src_ea(o_src_ea), .o_src_is_imm(o_src_is_imm),
	.o_src_word(o_src_word), .o_src_reg(o_src_reg), .o_src_ram(o_src_ram), .o_bit_valid(o_bit_valid),
	.o_bit_idx(o_bit_idx), .o_dst_ea(o_dst_ea), .o_dst_reg(o_dst_reg), .o_write_back(o_write_back));

`default_nettype wire

// file: testbench/oag_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "oag_defines.vh"

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
	$display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end

// ----------------------------------------
// Bench
// ----------------------------------------
module oag_top_tb;
	logic        i_ref_clk, i_rst_n, i_start, i_ptr_sel, i_word, i_addr_long, i_off_long;
	logic        i_dst_acc, i_dst_long, i_ib_valid, i_mem_rvalid;
	logic [1:0]  i_op_class, i_bit_op;
	logic [2:0]  i_mode, i_bit_num;
	logic [15:0] i_ptr1, i_ptr2;
	logic [7:0]  i_ib_data, i_mem_rdata;
	logic        o_ib_take, o_mem_rd, o_busy, o_done, o_illegal, o_src_is_imm, o_src_word, o_src_ram;
	logic        o_bit_valid, o_dst_valid, o_write_back;
	logic [2:0]  o_src_reg, o_bit_idx, o_dst_reg;
	logic [15:0] o_mem_addr, o_src_ea, o_imm, o_dst_ea;
	logic [7:0]  sq[$];
	logic [7:0]  mem[0:255];
	int          fails, n_compared, cycles, mem_lat, cyc;

	oag_top DUT (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_op_class(i_op_class),
		.i_mode(i_mode), .i_ptr_sel(i_ptr_sel), .i_word(i_word), .i_addr_long(i_addr_long),
		.i_off_long(i_off_long), .i_dst_acc(i_dst_acc), .i_dst_long(i_dst_long), .i_bit_op(i_bit_op),
		.i_bit_num(i_bit_num), .i_ptr1(i_ptr1), .i_ptr2(i_ptr2), .i_ib_valid(i_ib_valid), .i_ib_data(i_ib_data),
		.i_mem_rvalid(i_mem_rvalid), .i_mem_rdata(i_mem_rdata), .o_ib_take(o_ib_take), .o_mem_rd(o_mem_rd),
		.o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_src_ea(o_src_ea),
		.o_src_is_imm(o_src_is_imm), .o_imm(o_imm), .o_src_word(o_src_word), .o_src_reg(o_src_reg),
		.o_src_ram(o_src_ram), .o_bit_valid(o_bit_valid), .o_bit_idx(o_bit_idx), .o_dst_valid(o_dst_valid),
		.o_dst_ea(o_dst_ea), .o_dst_reg(o_dst_reg), .o_write_back(o_write_back));

	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	// Stream source: a byte leaves only after the block flags it taken
	initial forever begin
		@(posedge i_ref_clk);
		#1;
		if (o_ib_take === 1'b1) void'(sq.pop_front());
		i_ib_valid = (sq.size() != 0);
		i_ib_data = i_ib_valid ? sq[0] : ~i_ib_data;
	end

	// Base-page memory; data lines wander while no answer is due
	initial forever begin
		@(posedge i_ref_clk);
		#1;
		i_mem_rvalid = 1'b0;
		i_mem_rdata = ~i_mem_rdata;
		if (o_mem_rd === 1'b1) begin
			repeat (mem_lat) begin
				@(posedge i_ref_clk);
				#1;
				i_mem_rdata = ~i_mem_rdata;
			end
			i_mem_rvalid = 1'b1;
			i_mem_rdata = mem[o_mem_addr[7:0]];
		end
	end

	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic clr();
		{i_start, i_op_class, i_mode, i_ptr_sel, i_word, i_addr_long, i_off_long} = '0;
		{i_dst_acc, i_dst_long, i_bit_op, i_bit_num} = '0;
		sq.delete();
		mem_lat = 0;
	endtask

	task automatic go();
		i_start = 1'b1;
		@(posedge i_ref_clk);
		#1;
		i_start = 1'b0;
		cyc = 0;
		while (o_done !== 1'b1 && cyc < 60) begin
			@(posedge i_ref_clk);
			#1;
			cyc++;
		end
		if (cyc >= 60) fails++;
	endtask

	task automatic do_dir(input logic [15:0] a, input logic lng);
		clr();
		i_word = 1'b1;
		i_addr_long = lng;
		sq.push_back(a[7:0]);
		if (lng) sq.push_back(a[15:8]);
		go();
		`CHK(o_src_ea, a)
		`CHK(o_src_word, 1'b1)
		`CHK(o_src_ram, (a <= 16'h00BF))
	endtask

	task automatic t_direct();
		do_dir(16'h00C8, 1'b0);
		`CHK(o_src_reg, `OAG_R_ACC)
		do_dir(16'h00CE, 1'b0);
		`CHK(o_src_reg, `OAG_R_PTR2)
		do_dir(16'h00BF, 1'b0);
		do_dir(16'hF123, 1'b1);
		`CHK(o_src_reg, `OAG_R_NONE)
		$display("test direct done");
	endtask

	task automatic t_regind();
		i_ptr1 = 16'h4321;
		i_ptr2 = 16'h8765;
		for (int b = 0; b < 8; b++) begin
			clr();
			i_mode = `OAG_M_REGIND;
			i_ptr_sel = b[0];
			i_word = 1'b1;
			i_bit_op = (b[1:0] == 2'h0) ? `OAG_B_SET : b[1:0];
			i_bit_num = b[2:0];
			sq.push_back(8'hAA);
			go();
			`CHK(cyc, 1)
			`CHK(o_busy, 1'b0)
			`CHK(sq.size(), 1)
			`CHK(o_src_ea, (b[0] ? i_ptr2 : i_ptr1))
			`CHK(o_bit_idx, b[2:0])
			`CHK(o_src_word, 1'b0)
			`CHK(o_write_back, (i_bit_op != `OAG_B_TEST))
		end
		$display("test register indirect done");
	endtask

	task automatic t_mem();
		mem[8'h10] = 8'h34;
		mem[8'h11] = 8'h12;
		mem[8'hFF] = 8'hCD;
		mem[8'h00] = 8'hAB;
		clr();
		i_mode = `OAG_M_INDIRECT;
		mem_lat = 3;
		sq.push_back(8'h10);
		go();
		`CHK(o_src_ea, 16'h1234)
		clr();
		i_mode = `OAG_M_INDIRECT;
		sq.push_back(8'hFF);
		go();
		`CHK(o_src_ea, 16'hABCD)
		clr();
		i_mode = `OAG_M_INDEXED;
		sq = '{8'h10, 8'h05};
		go();
		`CHK(o_src_ea, 16'h1239)
		i_off_long = 1'b1;
		sq = '{8'h10, 8'h00, 8'hF0};
		go();
		`CHK(o_src_ea, 16'h0234)
		$display("test pointer modes done");
	endtask

	task automatic t_dbl();
		clr();
		i_mode = `OAG_M_DBLREG;
		i_bit_op = `OAG_B_SET;
		i_word = 1'b1;
		i_ptr1 = 16'h2000;
		i_ptr2 = 16'h0013;
		go();
		`CHK(o_src_ea, 16'h2002)
		`CHK(o_bit_idx, 3'h3)
		`CHK(o_src_word, 1'b0)
		`CHK(o_bit_valid, 1'b1)
		i_ptr2 = 16'hFFFF;
		i_bit_op = `OAG_B_CLEAR;
		go();
		`CHK(o_src_ea, 16'h3FFF)
		`CHK(o_bit_idx, 3'h7)
		i_bit_op = `OAG_B_NONE;
		go();
		`CHK(o_illegal, 1'b1)
		`CHK(o_bit_valid, 1'b0)
		$display("test bit string done");
	endtask

	task automatic t_two();
		clr();
		i_op_class = `OAG_C_TWO;
		i_dst_acc = 1'b1;
		i_mode = `OAG_M_IMMED;
		i_word = 1'b1;
		sq = '{8'h34, 8'h12};
		go();
		`CHK(o_src_is_imm, 1'b1)
		`CHK(o_imm, 16'h1234)
		`CHK(o_dst_ea, `OAG_A_ACC)
		`CHK(o_dst_valid, 1'b1)
		`CHK(o_dst_reg, `OAG_R_ACC)
		`CHK(o_write_back, 1'b1)
		i_op_class = `OAG_C_CMP;
		i_word = 1'b0;
		sq = '{8'h5A};
		go();
		`CHK(o_imm, 16'h005A)
		`CHK(o_write_back, 1'b0)
		i_mode = `OAG_M_REGIND;
		go();
		`CHK(o_illegal, 1'b0)
		clr();
		i_op_class = `OAG_C_TWO;
		sq = '{8'hF0, 8'h20};
		go();
		`CHK(o_dst_ea, 16'h00F0)
		`CHK(o_src_ea, 16'h0020)
		i_dst_long = 1'b1;
		sq = '{8'h34, 8'h12, 8'h20};
		go();
		`CHK(o_dst_ea, 16'h1234)
		`CHK(o_dst_reg, `OAG_R_NONE)
		i_dst_long = 1'b0;
		i_mode = `OAG_M_REGIND;
		go();
		`CHK(o_illegal, 1'b1)
		clr();
		i_mode = `OAG_M_IMMED;
		go();
		`CHK(o_illegal, 1'b1)
		$display("test two operand done");
	endtask

	initial begin
		i_rst_n = 1'b0;
		i_ib_valid = 1'b0;
		i_ib_data = 8'h00;
		i_mem_rvalid = 1'b0;
		i_mem_rdata = 8'h00;
		i_ptr1 = 16'h0000;
		i_ptr2 = 16'h0000;
		clr();
		repeat (16) @(posedge i_ref_clk);
		#1;
		i_rst_n = 1'b1;
		t_direct();
		t_regind();
		t_mem();
		t_dbl();
		t_two();
		stop_test();
	end
endmodule

`default_nettype wire
